// file: hdl/sdre_engine.sv
`timescale 1ns/1ps
module sdre_engine #(
   parameter int NDESC = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [12:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transmit fifo
   output logic tx_valid,
   output logic [31:0] tx_data,
   output logic [2:0] tx_nbytes,
   output logic tx_last,
   input wire logic tx_ready,
   // receive fifo
   input wire logic rx_valid,
   input wire logic [31:0] rx_data,
   input wire logic rx_wide,
   input wire logic rx_eof,
   input wire logic rx_err,
   output logic rx_ready
);
   localparam int PW = $clog2(NDESC);
   localparam int AW = sdre_pkg::MEM_AW;

   typedef enum logic [3:0] {
      ST_IDLE, ST_TX_DESC, ST_TX_DCHK, ST_TX_PTR, ST_TX_BUF, ST_TX_PUSH, ST_TX_CLOSE,
      ST_RX_DESC, ST_RX_DCHK, ST_RX_PTR, ST_RX_DATA, ST_RX_CLOSE
   } sdre_state_t;

   sdre_state_t state;
   sdre_state_t next_state;
   logic [1:0] ctrl;
   logic [sdre_pkg::EV_W-1:0] events;
   logic [15:0] rx_max;
   logic [PW-1:0] tx_current_desc_ptr;
   logic [PW-1:0] rx_current_desc_ptr;
   logic [15:0] desc_stat;
   logic [15:0] desc_len;
   logic [AW+1:0] buf_addr;
   logic [15:0] byte_cnt;
   logic rx_err_seen;
   logic [15:0] poll_cnt;
   logic last_rx;

   sdre_mem_if #(.AW(AW)) host_port ();
   sdre_mem_if #(.AW(AW)) eng_port ();

   // descriptor storage and data buffers
   // shared descriptor memory
   sdre_shared_mem #(.AW(AW)) u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .pa(host_port.slave),
      .pb(eng_port.slave)
   );

   // apb decode
   wire apb_setup = psel & ~penable;
   wire apb_access = psel & penable;
   wire mem_sel = paddr[12];
   wire [11:0] reg_ofs = paddr[11:0];
   wire hit_ctrl = reg_ofs == sdre_pkg::CTRL_OFS;
   wire hit_event = reg_ofs == sdre_pkg::EVENT_OFS;
   wire hit_status = reg_ofs == sdre_pkg::STATUS_OFS;
   wire hit_rxmax = reg_ofs == sdre_pkg::RXMAX_OFS;
   wire reg_hit = hit_ctrl | hit_event | hit_status | hit_rxmax;
   wire reg_wr = apb_access & pwrite & ~mem_sel & pstrb[0];
   wire tx_en = ctrl[sdre_pkg::CTRL_TX_EN_BIT];
   wire rx_en = ctrl[sdre_pkg::CTRL_RX_EN_BIT];

   // host memory window: read issued in setup, write in access
   assign host_port.en = mem_sel & (pwrite ? apb_access : apb_setup);
   assign host_port.we = pwrite;
   assign host_port.be = pstrb;
   assign host_port.addr = paddr[AW+1:2];
   assign host_port.wdata = pwdata;

   // read mux and answer
   wire [31:0] status_word = {23'h000000, state != ST_IDLE,
      4'(rx_current_desc_ptr), 4'(tx_current_desc_ptr)};
   wire [31:0] reg_rdata = hit_ctrl ? {30'h00000000, ctrl} :
                           hit_event ? {28'h0000000, events} :
                           hit_status ? status_word :
                           hit_rxmax ? {16'h0000, rx_max} : 32'h0000_0000;
   assign prdata = mem_sel ? host_port.rdata : reg_rdata;
   assign pready = 1'b1;
   assign pslverr = apb_access & ~mem_sel & ~reg_hit;

   // descriptor word addresses
   // eight-byte descriptors
   wire [AW-1:0] tx_d0_addr = AW'((sdre_pkg::TX_TBL_BASE
      + sdre_pkg::DESC_BYTES * int'(tx_current_desc_ptr)) / 4);
   wire [AW-1:0] rx_d0_addr = AW'((sdre_pkg::RX_TBL_BASE
      + sdre_pkg::DESC_BYTES * int'(rx_current_desc_ptr)) / 4);
   wire [AW-1:0] tx_d1_addr = tx_d0_addr + AW'(sdre_pkg::DESC_PTR_OFS / 4);
   wire [AW-1:0] rx_d1_addr = rx_d0_addr + AW'(sdre_pkg::DESC_PTR_OFS / 4);
   wire [15:0] rd_stat = eng_port.rdata[15:0];
   wire [15:0] rd_len = eng_port.rdata[8*sdre_pkg::DESC_LEN_OFS +: 16];
   wire rd_flag = rd_stat[sdre_pkg::FLAG_RDY_BIT];
   wire desc_wrap = desc_stat[sdre_pkg::FLAG_WRAP_BIT];

   // transmit remaining bytes
   wire [15:0] tx_rem = desc_len - byte_cnt;
   wire tx_done = byte_cnt >= desc_len;
   assign tx_valid = state == ST_TX_PUSH;
   assign tx_data = eng_port.rdata;
   assign tx_nbytes = (tx_rem >= 16'h0004) ? 3'h4 : tx_rem[2:0];
   assign tx_last = tx_rem <= 16'h0004;

   // receive step
   assign rx_ready = state == ST_RX_DATA;
   wire rx_take = rx_ready & rx_valid;
   wire [15:0] rx_step = rx_wide ? 16'h0004 : 16'h0001;
   wire [15:0] rx_cnt_new = byte_cnt + rx_step;
   wire rx_close = rx_cnt_new >= rx_max | rx_eof | rx_err;

   // pointer advance
   // wrap to first
   wire ptr_last_tx = desc_wrap | (int'(tx_current_desc_ptr) == NDESC - 1);
   wire ptr_last_rx = desc_wrap | (int'(rx_current_desc_ptr) == NDESC - 1);
   wire [PW-1:0] next_tx_ptr = ptr_last_tx ? '0 : tx_current_desc_ptr + PW'(1);
   wire [PW-1:0] next_rx_ptr = ptr_last_rx ? '0 : rx_current_desc_ptr + PW'(1);

   // scheduling
   wire poll_due = poll_cnt == 16'h0000;
   wire want_rx = rx_en & rx_valid & poll_due;
   wire want_tx = tx_en & poll_due;
   wire pick_rx = want_rx & (~want_tx | ~last_rx);
   wire tx_state = state inside {ST_TX_DESC, ST_TX_DCHK, ST_TX_PTR, ST_TX_BUF,
      ST_TX_PUSH, ST_TX_CLOSE};
   wire rx_state = state inside {ST_RX_DESC, ST_RX_DCHK, ST_RX_PTR, ST_RX_DATA,
      ST_RX_CLOSE};
   wire abort = (tx_state & ~tx_en) | (rx_state & ~rx_en);

   // event sets
   wire [sdre_pkg::EV_W-1:0] ev_set;
   assign ev_set[sdre_pkg::EV_TX_BUF_BIT] = state == ST_TX_CLOSE;
   assign ev_set[sdre_pkg::EV_RX_BUF_BIT] = state == ST_RX_CLOSE;
   assign ev_set[sdre_pkg::EV_BUSY_BIT] = state == ST_RX_DCHK & ~rd_flag & rx_en;
   assign ev_set[sdre_pkg::EV_RX_ERR_BIT] = state == ST_RX_CLOSE & rx_err_seen;
   wire [sdre_pkg::EV_W-1:0] ev_clr = (reg_wr & hit_event) ?
      pwdata[sdre_pkg::EV_W-1:0] : '0;

   // next state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (pick_rx) begin
               next_state = ST_RX_DESC;
            end else if (want_tx) begin
               next_state = ST_TX_DESC;
            end
         end
         ST_TX_DESC: next_state = ST_TX_DCHK;
         ST_TX_DCHK: next_state = rd_flag ? ST_TX_PTR : ST_IDLE;
         ST_TX_PTR: next_state = ST_TX_BUF;
         ST_TX_BUF: next_state = tx_done ? ST_TX_CLOSE : ST_TX_PUSH;
         ST_TX_PUSH: next_state = tx_ready ? ST_TX_BUF : ST_TX_PUSH;
         ST_TX_CLOSE: next_state = ST_IDLE;
         ST_RX_DESC: next_state = ST_RX_DCHK;
         ST_RX_DCHK: next_state = rd_flag ? ST_RX_PTR : ST_IDLE;
         ST_RX_PTR: next_state = ST_RX_DATA;
         ST_RX_DATA: next_state = (rx_take & rx_close) ? ST_RX_CLOSE : ST_RX_DATA;
         ST_RX_CLOSE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
      if (abort) begin
         next_state = ST_IDLE;
      end
   end

   // engine memory port
   always_comb begin
      eng_port.en = 1'b0;
      eng_port.we = 1'b0;
      eng_port.be = 4'h0;
      eng_port.addr = '0;
      eng_port.wdata = 32'h0000_0000;
      unique case (state)
         ST_TX_DESC: begin
            eng_port.en = 1'b1;
            eng_port.addr = tx_d0_addr;
         end
         ST_TX_DCHK: begin
            eng_port.en = rd_flag;
            eng_port.addr = tx_d1_addr;
         end
         ST_TX_BUF: begin
            eng_port.en = ~tx_done;
            eng_port.addr = buf_addr[AW+1:2];
         end
         ST_TX_CLOSE: begin
            eng_port.en = 1'b1;
            eng_port.we = 1'b1;
            eng_port.be = 4'h3;
            eng_port.addr = tx_d0_addr;
            eng_port.wdata = {16'h0000, desc_stat & ~(16'h0001 << sdre_pkg::FLAG_RDY_BIT)};
         end
         ST_RX_DESC: begin
            eng_port.en = 1'b1;
            eng_port.addr = rx_d0_addr;
         end
         ST_RX_DCHK: begin
            eng_port.en = rd_flag;
            eng_port.addr = rx_d1_addr;
         end
         ST_RX_DATA: begin
            eng_port.en = rx_take;
            eng_port.we = 1'b1;
            eng_port.be = rx_wide ? 4'hf : (4'h1 << buf_addr[1:0]);
            eng_port.addr = buf_addr[AW+1:2];
            eng_port.wdata = rx_wide ? rx_data : {4{rx_data[7:0]}};
         end
         ST_RX_CLOSE: begin
            eng_port.en = 1'b1;
            eng_port.we = 1'b1;
            eng_port.be = 4'hf;
            eng_port.addr = rx_d0_addr;
            eng_port.wdata = {byte_cnt, (desc_stat & ~(16'h0001 << sdre_pkg::FLAG_RDY_BIT))
               | (rx_err_seen ? (16'h0001 << sdre_pkg::FLAG_ERR_BIT) : 16'h0000)};
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= sdre_pkg::CTRL_RST;
         rx_max <= sdre_pkg::RXMAX_RST;
      end else if (reg_wr) begin
         if (hit_ctrl) begin
            ctrl <= pwdata[1:0];
         end
         if (hit_rxmax) begin
            rx_max <= pwdata[15:0];
         end
      end
   end

   // sticky events, set beats clear
   // write one to clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         events <= sdre_pkg::EV_RST;
      end else begin
         events <= (events & ~ev_clr) | ev_set;
      end
   end

   // transmit pointer
   // circular pointers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_current_desc_ptr <= '0;
      end else if (!tx_en) begin
         tx_current_desc_ptr <= '0;
      end else if (state == ST_TX_CLOSE) begin
         tx_current_desc_ptr <= next_tx_ptr;
      end
   end

   // receive pointer
   // start at first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_current_desc_ptr <= '0;
      end else if (!rx_en) begin
         rx_current_desc_ptr <= '0;
      end else if (state == ST_RX_CLOSE) begin
         rx_current_desc_ptr <= next_rx_ptr;
      end
   end

   // latched descriptor fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         desc_stat <= 16'h0000;
         desc_len <= 16'h0000;
      end else if ((state == ST_TX_DCHK || state == ST_RX_DCHK) && rd_flag) begin
         desc_stat <= rd_stat;
         desc_len <= rd_len;
      end
   end

   // buffer address and byte count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_addr <= '0;
         byte_cnt <= 16'h0000;
      end else if (state == ST_TX_PTR || state == ST_RX_PTR) begin
         buf_addr <= eng_port.rdata[AW+1:0];
         byte_cnt <= 16'h0000;
      end else if (state == ST_TX_PUSH && tx_ready) begin
         buf_addr <= buf_addr + (AW+2)'(4);
         byte_cnt <= byte_cnt + 16'h0004;
      end else if (rx_take) begin
         buf_addr <= buf_addr + (AW+2)'(rx_step);
         byte_cnt <= rx_cnt_new;
      end
   end

   // receive error capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_err_seen <= 1'b0;
      end else if (state == ST_RX_PTR) begin
         rx_err_seen <= 1'b0;
      end else if (rx_take && rx_err) begin
         rx_err_seen <= 1'b1;
      end
   end

   // poll interval after a failed check
   // periodic poll
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poll_cnt <= 16'h0000;
      end else if ((state == ST_TX_DCHK || state == ST_RX_DCHK) && !rd_flag) begin
         poll_cnt <= 16'(sdre_pkg::POLL_CYC - 1);
      end else if (!poll_due) begin
         poll_cnt <= poll_cnt - 16'h0001;
      end
   end

   // fairness between sides
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_rx <= 1'b0;
      end else if (state == ST_IDLE && (want_rx || want_tx)) begin
         last_rx <= pick_rx;
      end
   end
endmodule : sdre_engine

// file: hdl/sdre_mem_if.sv
`timescale 1ns/1ps
interface sdre_mem_if #(parameter int AW = 10);
   logic en;
   logic we;
   logic [3:0] be;
   logic [AW-1:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport master (output en, output we, output be, output addr, output wdata, input rdata);
   modport slave (input en, input we, input be, input addr, input wdata, output rdata);
endinterface : sdre_mem_if

// file: hdl/sdre_pkg.sv
package sdre_pkg;
   // clock and polling
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned POLL_NS = 1000;
   localparam int unsigned POLL_CYC = (POLL_NS * CLK_MHZ + 999) / 1000;

   // shared memory geometry
   localparam int unsigned MEM_AW = 10;
   localparam int unsigned APB_AW = 13;

   // register byte offsets, memory window selected by paddr[12]
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] EVENT_OFS = 12'h004;
   localparam logic [11:0] STATUS_OFS = 12'h008;
   localparam logic [11:0] RXMAX_OFS = 12'h00c;

   // control fields
   localparam int unsigned CTRL_TX_EN_BIT = 0;
   localparam int unsigned CTRL_RX_EN_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [15:0] RXMAX_RST = 16'h0040;

   // event fields, write one to clear
   localparam int unsigned EV_TX_BUF_BIT = 0;
   localparam int unsigned EV_RX_BUF_BIT = 1;
   localparam int unsigned EV_BUSY_BIT = 2;
   localparam int unsigned EV_RX_ERR_BIT = 3;
   localparam int unsigned EV_W = 4;
   localparam logic [3:0] EV_RST = 4'h0;

   // status fields
   localparam int unsigned STAT_TXPTR_LSB = 0;
   localparam int unsigned STAT_RXPTR_LSB = 4;
   localparam int unsigned STAT_ACTIVE_BIT = 8;

   // descriptor layout, byte offsets inside an 8-byte descriptor
   localparam int unsigned DESC_BYTES = 8;
   localparam int unsigned DESC_STAT_OFS = 0;
   localparam int unsigned DESC_LEN_OFS = 2;
   localparam int unsigned DESC_PTR_OFS = 4;
   localparam int unsigned FLAG_RDY_BIT = 15;
   localparam int unsigned FLAG_WRAP_BIT = 13;
   localparam int unsigned FLAG_ERR_BIT = 0;

   // descriptor tables, byte addresses in shared memory
   localparam int unsigned TX_TBL_BASE = 32'h0000_0000;
   localparam int unsigned RX_TBL_BASE = 32'h0000_0040;
   localparam int unsigned MAX_DESC = 8;
endpackage : sdre_pkg

// file: hdl/sdre_shared_mem.sv
`timescale 1ns/1ps
module sdre_shared_mem #(
   parameter int AW = 10
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // host port and engine port
   sdre_mem_if.slave pa,
   sdre_mem_if.slave pb
);
   logic [31:0] mem [2**AW];

   // byte-lane writes from both ports, engine wins on a collision
   always_ff @(posedge pclk) begin
      for (int i = 0; i < 4; i++) begin
         if (pa.en && pa.we && pa.be[i]) begin
            mem[pa.addr][8*i +: 8] <= pa.wdata[8*i +: 8];
         end
         if (pb.en && pb.we && pb.be[i]) begin
            mem[pb.addr][8*i +: 8] <= pb.wdata[8*i +: 8];
         end
      end
   end

   // read data holds until the next read on that port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pa.rdata <= 32'h0000_0000;
         pb.rdata <= 32'h0000_0000;
      end else begin
         if (pa.en && !pa.we) begin
            pa.rdata <= mem[pa.addr];
         end
         if (pb.en && !pb.we) begin
            pb.rdata <= mem[pb.addr];
         end
      end
   end
endmodule : sdre_shared_mem

// file: tb/sdre_assertions.sv
`timescale 1ns/1ps
module sdre_assertions #(
   parameter int NDESC = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [12:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // transmit fifo
   input wire logic tx_valid,
   input wire logic [31:0] tx_data,
   input wire logic [2:0] tx_nbytes,
   input wire logic tx_last,
   input wire logic tx_ready,
   // receive fifo
   input wire logic rx_valid,
   input wire logic [31:0] rx_data,
   input wire logic rx_wide,
   input wire logic rx_eof,
   input wire logic rx_err,
   input wire logic rx_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_acc;
   assign wr_acc = psel && penable && pwrite;
   AST_TX_HOLD: assert property (tx_valid && !tx_ready && !wr_acc |=> tx_valid &&
      $stable(tx_data) && $stable(tx_nbytes) && $stable(tx_last))
      else $error("tx word changed before taken");
   AST_TX_GAP: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("tx word offered right after take");
   AST_TX_NB: assert property (tx_valid |-> tx_nbytes inside {[3'h1:3'h4]})
      else $error("tx byte count out of range");
   AST_TX_FULL: assert property (tx_valid && !tx_last |-> tx_nbytes == 3'h4)
      else $error("inner tx word not full");
   AST_RX_CLOSE: assert property (rx_valid && rx_ready && (rx_eof || rx_err)
      |=> !rx_ready) else $error("rx buffer not closed");
   AST_RX_STAY: assert property (rx_ready && !rx_valid && !wr_acc |=> rx_ready)
      else $error("rx buffer closed without cause");
   AST_RX_CAUSE: assert property ($rose(rx_ready) |-> $past(rx_valid))
      else $error("rx buffer opened with no data");
   AST_MEM_OK: assert property (psel && penable && paddr[12] |-> pready && !pslverr)
      else $error("memory window access refused");
   CV_TX_LAST: cover property (tx_valid && tx_ready && tx_last);
   CV_RX_CLOSE: cover property (rx_valid && rx_ready && rx_eof);
   CV_RX_BYTE: cover property (rx_valid && rx_ready && !rx_wide && rx_err);
endmodule : sdre_assertions

// file: tb/sdre_fifo_model.sv
`timescale 1ns/1ps
module sdre_fifo_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // stall control
   input wire logic slow,
   // transmit fifo
   input wire logic tx_valid,
   input wire logic [31:0] tx_data,
   input wire logic [2:0] tx_nbytes,
   input wire logic tx_last,
   output logic tx_ready,
   // receive fifo
   output logic rx_valid,
   output logic [31:0] rx_data,
   output logic rx_wide,
   output logic rx_eof,
   output logic rx_err,
   input wire logic rx_ready
);
   logic [35:0] txq[$];
   logic [34:0] rxq[$];
   logic tick;
   always @(posedge pclk) begin
      if (!presetn) begin
         tick <= 1'b0;
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_data <= 32'h0;
         rx_wide <= 1'b0;
         rx_eof <= 1'b0;
         rx_err <= 1'b0;
      end else begin
         tick <= ~tick;
         tx_ready <= !slow || tick;
         if (tx_valid && tx_ready) begin
            txq.push_back({tx_last, tx_nbytes, tx_data});
         end
         if (rx_valid && rx_ready) begin
            rxq.delete(0);
         end
         if (rxq.size() > 0) begin
            {rx_wide, rx_eof, rx_err, rx_data} <= rxq[0];
            rx_valid <= 1'b1;
         end else begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
         end
      end
   end
endmodule : sdre_fifo_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // clock and reset
   logic pclk;
   logic presetn;
   // apb
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [12:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   // fifo
   logic tx_valid, tx_last, tx_ready, rx_valid, rx_wide, rx_eof, rx_err, rx_ready, slow;
   logic [31:0] tx_data, rx_data;
   logic [2:0] tx_nbytes;
   int bad_count, n_tests, cyc;
   localparam logic [12:0] M = 13'h1000;
   localparam logic [12:0] A_CTRL = {1'b0, sdre_pkg::CTRL_OFS};
   localparam logic [12:0] A_EV = {1'b0, sdre_pkg::EVENT_OFS};
   localparam logic [12:0] A_STAT = {1'b0, sdre_pkg::STATUS_OFS};
   localparam logic [12:0] A_RXMAX = {1'b0, sdre_pkg::RXMAX_OFS};

   sdre_engine #(.NDESC(8)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_valid, .tx_data, .tx_nbytes,
      .tx_last, .tx_ready, .rx_valid, .rx_data, .rx_wide, .rx_eof, .rx_err, .rx_ready);
   sdre_fifo_model i_fifo (.pclk, .presetn, .slow, .tx_valid, .tx_data, .tx_nbytes,
      .tx_last, .tx_ready, .rx_valid, .rx_data, .rx_wide, .rx_eof, .rx_err, .rx_ready);

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic final_report();
      if (bad_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [12:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic poll(input logic [12:0] a, input logic [31:0] m, input logic [31:0] want);
      int n;
      n = 0;
      do begin
         rd(a);
         n++;
      end while ((q & m) !== want && n < 400);
      chk(q & m, want);
   endtask : poll

   task automatic wait_q(input bit rxs, input int k);
      while (rxs ? i_fifo.rxq.size() > k : i_fifo.txq.size() < k) begin
         @(posedge pclk);
      end
   endtask : wait_q

   task automatic t_regs();
      rd(A_CTRL);
      chk(q, 32'h0);
      rd(A_EV);
      chk(q, 32'h0);
      rd(A_STAT);
      chk(q, 32'h0);
      rd(A_RXMAX);
      chk(q, 32'h40);
      rd(13'h0010);
      chk({q, err}, 33'h1);
   endtask : t_regs

   task automatic t_tx();
      wr(M + 13'h100, 32'h4433_2211);
      wr(M + 13'h104, 32'h0000_6655);
      wr(M + 13'h108, 32'hddcc_bbaa);
      wr(M + 13'h004, 32'h100);
      wr(M + 13'h00c, 32'h108);
      wr(M + 13'h000, 32'h0006_0000);
      wr(M + 13'h008, 32'h0004_a000);
      wr(A_CTRL, 32'h1);
      repeat (300) @(posedge pclk);
      chk(i_fifo.txq.size(), 0);
      wr(M + 13'h000, 32'h0006_8000);
      wait_q(1'b0, 3);
      chk(i_fifo.txq[0], {4'h4, 32'h4433_2211});
      chk(i_fifo.txq[1], {4'ha, 32'h0000_6655});
      chk(i_fifo.txq[2], {4'hc, 32'hddcc_bbaa});
      poll(M + 13'h008, 32'h8000, 32'h0);
      poll(M + 13'h000, 32'hffff_8000, 32'h0006_0000);
      rd(A_STAT);
      chk(q[3:0], 4'h0);
      rd(A_EV);
      chk(q[0], 1'b1);
      wr(A_EV, 32'h1);
      rd(A_EV);
      chk(q[0], 1'b0);
      wr(M + 13'h000, 32'h0);
      wr(M + 13'h008, 32'h0);
      repeat (450) @(posedge pclk);
      chk(i_fifo.txq.size(), 3);
   endtask : t_tx

   task automatic t_rx();
      wr(M + 13'h044, 32'h200);
      wr(M + 13'h040, 32'h0000_8000);
      wr(M + 13'h04c, 32'h240);
      wr(M + 13'h048, 32'h0);
      wr(A_CTRL, 32'h3);
      i_fifo.rxq.push_back({3'h4, 32'h1122_3344});
      i_fifo.rxq.push_back({3'h6, 32'h5566_7788});
      wait_q(1'b1, 0);
      poll(M + 13'h040, 32'hffff_ffff, 32'h0008_0000);
      rd(M + 13'h200);
      chk(q, 32'h1122_3344);
      rd(M + 13'h204);
      chk(q, 32'h5566_7788);
      rd(A_EV);
      chk(q[1], 1'b1);
      rd(A_STAT);
      chk(q[7:4], 4'h1);
      i_fifo.rxq.push_back({3'h1, 32'h0000_00a5});
      poll(A_EV, 32'h4, 32'h4);
      rd(A_STAT);
      chk(q[7:4], 4'h1);
      chk(i_fifo.rxq.size(), 1);
      wr(M + 13'h048, 32'h0000_8000);
      wait_q(1'b1, 0);
      poll(M + 13'h048, 32'hffff_8001, 32'h0001_0001);
      rd(M + 13'h240);
      chk(q[7:0], 8'ha5);
      rd(A_EV);
      chk(q[3], 1'b1);
      wr(M + 13'h054, 32'h280);
      wr(M + 13'h050, 32'h0000_8000);
      wr(A_RXMAX, 32'h4);
      i_fifo.rxq.push_back({3'h4, 32'h99aa_bbcc});
      wait_q(1'b1, 0);
      poll(M + 13'h050, 32'hffff_8000, 32'h0004_0000);
      rd(M + 13'h280);
      chk(q, 32'h99aa_bbcc);
      wr(A_CTRL, 32'h0);
      rd(A_STAT);
      chk(q[7:0], 8'h0);
   endtask : t_rx

   initial begin
      cyc = 0;
      bad_count = 0;
      n_tests = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 13'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      slow = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_tx();
      t_rx();
      final_report();
   end
endmodule : tb_top

bind sdre_engine sdre_assertions #(.NDESC(NDESC)) i_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_valid, .tx_data,
   .tx_nbytes, .tx_last, .tx_ready, .rx_valid, .rx_data, .rx_wide, .rx_eof, .rx_err, .rx_ready);
